// File: hw/mui_core.sv
// serial music interface: host byte ports, mode handling, fifos, serial link
// assumes host strobes are one-cycle pulses synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module mui_core
  import mui_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [15:0] cfg_base_addr,
  input wire logic [3:0] cfg_irq_level,
  input wire logic [7:0] special_config_register,
  input wire logic serial_input_pin,
  output logic serial_output_pin,
  output logic irq_req,
  output logic [3:0] irq_level,
  output logic rx_buffer_empty_flag,
  output logic tx_buffer_full_flag
);
  localparam int CW = $clog2(MUI_FIFO_DEPTH + 1);

  typedef struct packed {
    mui_mode_t mode;
    logic [7:0] rdata;
    logic ack_irq;
    logic [3:0] irq_lvl;
    mui_ser_t tx_st;
    logic [MUI_TMR_W-1:0] tx_tmr;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_out;
    mui_ser_t rx_st;
    logic [MUI_TMR_W-1:0] rx_tmr;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
  } mui_core_st_t;

  mui_core_st_t s_q, s_d;

  // returns 1 when the address lands in the two-byte window at offset ofs
  function automatic logic mui_sel(input logic [15:0] a, input logic [15:0] base,
                                   input logic ofs);
    logic [15:0] diff;
    diff = a - base;
    mui_sel = (diff[15:1] == 15'h0000) && (diff[0] == ofs);
  endfunction

  logic data_rd, data_wr, cmd_wr, stat_rd;
  logic flush;
  logic tx_push, tx_ready, tx_valid, tx_pop;
  logic [7:0] tx_data;
  logic [CW-1:0] tx_cnt;
  logic rx_push, rx_ready, rx_valid, rx_pop, rx_frame_ok;
  logic [7:0] rx_wdata, rx_data;
  logic [CW-1:0] rx_cnt;
  logic [4:0] trig;
  logic level_irq;

  assign data_rd = io_rd && mui_sel(io_addr, cfg_base_addr, MUI_OFS_DATA);
  assign data_wr = io_wr && mui_sel(io_addr, cfg_base_addr, MUI_OFS_DATA);
  assign stat_rd = io_rd && mui_sel(io_addr, cfg_base_addr, MUI_OFS_CMD);
  assign cmd_wr = io_wr && mui_sel(io_addr, cfg_base_addr, MUI_OFS_CMD);

  // unknown command codes fall through with no effect
  assign flush = cmd_wr && (io_wdata == MUI_CMD_RESET);

  // transmit side: data writes only queue in uart mode
  assign tx_push = data_wr && (s_q.mode == MUI_UART);
  assign tx_pop = tx_valid && (s_q.tx_st == MUI_SER_IDLE) && (s_q.mode == MUI_UART) && !flush;

  // receive side: acknowledge on mode entry, else completed frames in uart mode
  assign rx_frame_ok = (s_q.rx_st == MUI_SER_STOP) && (s_q.rx_tmr == MUI_BIT_LAST)
                       && serial_input_pin;
  assign rx_push = (cmd_wr && (io_wdata == MUI_CMD_UART) && (s_q.mode == MUI_INTEL))
                   || (rx_frame_ok && (s_q.mode == MUI_UART));
  assign rx_wdata = (s_q.mode == MUI_INTEL) ? MUI_ACK_CODE : s_q.rx_sh;
  assign rx_pop = data_rd && (s_q.mode == MUI_UART);

  mui_fifo #(.W(MUI_DATA_BITS), .D(MUI_FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .flush(flush),
    .wr_valid(tx_push),
    .wr_data(io_wdata),
    .wr_ready(tx_ready),
    .rd_ready(tx_pop),
    .rd_valid(tx_valid),
    .rd_data(tx_data),
    .count(tx_cnt)
  );

  mui_fifo #(.W(MUI_DATA_BITS), .D(MUI_FIFO_DEPTH)) u_rx_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .flush(flush),
    .wr_valid(rx_push),
    .wr_data(rx_wdata),
    .wr_ready(rx_ready),
    .rd_ready(rx_pop),
    .rd_valid(rx_valid),
    .rd_data(rx_data),
    .count(rx_cnt)
  );

  // intelligent mode always shows a held acknowledge byte
  assign rx_buffer_empty_flag = (s_q.mode == MUI_UART) ? !rx_valid : 1'b0;
  assign tx_buffer_full_flag = !tx_ready;

  assign trig = mui_trig(special_config_register[MUI_TRIG_LSB +: 2]);
  assign level_irq = (s_q.mode == MUI_UART) && (rx_cnt >= trig);
  assign irq_req = level_irq || s_q.ack_irq;
  assign irq_level = s_q.irq_lvl;
  assign io_rdata = s_q.rdata;
  assign serial_output_pin = s_q.tx_out;

  always_comb begin
    s_d = s_q;
    s_d.irq_lvl = cfg_irq_level;
    // host read data
    if (data_rd) begin
      s_d.rdata = (s_q.mode == MUI_INTEL) ? MUI_ACK_CODE : rx_data;
    end else if (stat_rd) begin
      s_d.rdata = {rx_buffer_empty_flag, tx_buffer_full_flag, MUI_STATUS_RSVD};
    end
    // acknowledge interrupt: a data read clears it, a new entry sets it
    if (data_rd) begin
      s_d.ack_irq = 1'b0;
    end
    if (cmd_wr && (io_wdata == MUI_CMD_UART) && (s_q.mode == MUI_INTEL)) begin
      s_d.mode = MUI_UART;
      s_d.ack_irq = 1'b1;
    end
    // transmitter
    case (s_q.tx_st)
      MUI_SER_IDLE: begin
        s_d.tx_out = 1'b1;
        if (tx_pop) begin
          s_d.tx_st = MUI_SER_START;
          s_d.tx_sh = tx_data;
          s_d.tx_tmr = '0;
          s_d.tx_out = 1'b0;
        end
      end
      MUI_SER_START: begin
        if (s_q.tx_tmr == MUI_BIT_LAST) begin
          s_d.tx_tmr = '0;
          s_d.tx_st = MUI_SER_DATA;
          s_d.tx_bit = '0;
          s_d.tx_out = s_q.tx_sh[0];
        end else begin
          s_d.tx_tmr = s_q.tx_tmr + 1'b1;
        end
      end
      MUI_SER_DATA: begin
        if (s_q.tx_tmr == MUI_BIT_LAST) begin
          s_d.tx_tmr = '0;
          if (s_q.tx_bit == MUI_LAST_BIT) begin
            s_d.tx_st = MUI_SER_STOP;
            s_d.tx_out = 1'b1;
          end else begin
            s_d.tx_bit = s_q.tx_bit + 1'b1;
            s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
            s_d.tx_out = s_q.tx_sh[1];
          end
        end else begin
          s_d.tx_tmr = s_q.tx_tmr + 1'b1;
        end
      end
      MUI_SER_STOP: begin
        if (s_q.tx_tmr == MUI_BIT_LAST) begin
          s_d.tx_tmr = '0;
          s_d.tx_st = MUI_SER_IDLE;
        end else begin
          s_d.tx_tmr = s_q.tx_tmr + 1'b1;
        end
      end
      default: s_d.tx_st = MUI_SER_IDLE;
    endcase
    // receiver: start confirmed at mid bit, then sampled once per bit time
    case (s_q.rx_st)
      MUI_SER_IDLE: begin
        if (!serial_input_pin) begin
          s_d.rx_st = MUI_SER_START;
          s_d.rx_tmr = '0;
        end
      end
      MUI_SER_START: begin
        if (s_q.rx_tmr == MUI_HALF_LAST) begin
          s_d.rx_tmr = '0;
          s_d.rx_bit = '0;
          s_d.rx_st = serial_input_pin ? MUI_SER_IDLE : MUI_SER_DATA;
        end else begin
          s_d.rx_tmr = s_q.rx_tmr + 1'b1;
        end
      end
      MUI_SER_DATA: begin
        if (s_q.rx_tmr == MUI_BIT_LAST) begin
          s_d.rx_tmr = '0;
          s_d.rx_sh = {serial_input_pin, s_q.rx_sh[7:1]};
          if (s_q.rx_bit == MUI_LAST_BIT) begin
            s_d.rx_st = MUI_SER_STOP;
          end else begin
            s_d.rx_bit = s_q.rx_bit + 1'b1;
          end
        end else begin
          s_d.rx_tmr = s_q.rx_tmr + 1'b1;
        end
      end
      MUI_SER_STOP: begin
        if (s_q.rx_tmr == MUI_BIT_LAST) begin
          s_d.rx_tmr = '0;
          s_d.rx_st = MUI_SER_IDLE;
        end else begin
          s_d.rx_tmr = s_q.rx_tmr + 1'b1;
        end
      end
      default: s_d.rx_st = MUI_SER_IDLE;
    endcase
    // reset command returns mode, interrupt, serial state and fifos to the power-up condition; read data holds
    if (flush) begin
      s_d.mode = MUI_INTEL;
      s_d.ack_irq = 1'b0;
      s_d.tx_st = MUI_SER_IDLE;
      s_d.tx_tmr = '0;
      s_d.tx_out = 1'b1;
      s_d.rx_st = MUI_SER_IDLE;
      s_d.rx_tmr = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.tx_out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_enter_uart;
    (s_q.mode == MUI_INTEL) && cmd_wr && (io_wdata == MUI_CMD_UART);
  endsequence
  sequence s_uart_ack;
    (s_q.mode == MUI_UART) && irq_req && rx_valid && (rx_data == MUI_ACK_CODE);
  endsequence
  sequence s_tx_launch;
    (s_q.tx_st == MUI_SER_IDLE) && tx_pop;
  endsequence
  sequence s_tx_start_bit;
    !serial_output_pin && (s_q.tx_st == MUI_SER_START);
  endsequence

  a_status_reserved: assert property (stat_rd |=> io_rdata[5:0] == 6'h3f)
    else $error("status reserved bits wrong");
  a_intel_read_ack: assert property ((data_rd && s_q.mode == MUI_INTEL) |=> io_rdata == 8'hfe)
    else $error("intelligent data read not ack");
  a_rx_empty_flag: assert property ((stat_rd && s_q.mode == MUI_UART) |=> io_rdata[7] == $past(!rx_valid))
    else $error("receive empty bit wrong");
  a_tx_full_flag: assert property (stat_rd |=> io_rdata[6] == ($past(tx_cnt) == 5'd16))
    else $error("transmit full bit wrong");
  a_uart_entry_ack: assert property (s_enter_uart |=> s_uart_ack)
    else $error("uart entry lacks ack or interrupt");
  a_reset_cmd_mode: assert property (flush |=> (s_q.mode == MUI_INTEL) && !rx_valid && !tx_valid)
    else $error("reset command did not restore");
  a_intel_write_drop: assert property ((data_wr && s_q.mode == MUI_INTEL) |=> tx_cnt == $past(tx_cnt))
    else $error("intelligent data write queued");
  a_irq_trigger: assert property ((s_q.mode == MUI_UART && !s_q.ack_irq) |-> irq_req == ({1'b0, rx_cnt} >= trig))
    else $error("receive interrupt mismatch");
  a_tx_start_bit: assert property (s_tx_launch |=> s_tx_start_bit [*8])
    else $error("start bit not low");
  a_tx_stop_high: assert property ((s_q.tx_st == MUI_SER_STOP) |-> serial_output_pin)
    else $error("stop bit not high");
  a_bit_timer: assert property ((s_q.tx_st != MUI_SER_IDLE && s_q.tx_tmr == MUI_BIT_LAST) |=> s_q.tx_tmr == '0)
    else $error("bit timer overran");
endmodule // mui_core
`default_nettype wire

// File: hw/mui_fifo.sv
// byte queue with valid/ready on both sides and a synchronous flush
// assumes depth is a power of two
`timescale 1ns/100ps
`default_nettype none
module mui_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  output logic wr_ready,
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  output logic [$clog2(D+1)-1:0] count
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } mui_fifo_st_t;

  mui_fifo_st_t s_q, s_d;
  logic push, pop;

  assign wr_ready = (s_q.cnt != FULL);
  assign rd_valid = (s_q.cnt != '0);
  assign rd_data = s_q.mem[s_q.rp];
  assign count = s_q.cnt;
  assign push = wr_valid && wr_ready;
  assign pop = rd_ready && rd_valid;

  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wp] = wr_data;
        s_d.wp = s_q.wp + 1'b1;
      end
      if (pop) begin
        s_d.rp = s_q.rp + 1'b1;
      end
      if (push && !pop) begin
        s_d.cnt = s_q.cnt + 1'b1;
      end else if (pop && !push) begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // mui_fifo
`default_nettype wire

// File: include/mui_pkg.sv
// constants, types and helpers shared by the serial music interface
// assumes a single 10 MHz clock and a host that strobes byte reads and writes
// Functional notes
// - frame: start, eight data, one stop
// - fixed 31.25 Kbaud both directions, not programmable
// - data at base+0, command/status at base+1
// - base address and interrupt level configurable
// - sixteen byte transmit and receive fifos
// - offset one: write command, read status
// - status bit 7 set when receive empty
// - status bit 6 set when transmit full
// - status bits 5..0 always read 3fh
// - only ffh and 3fh commands act
// - reset starts in intelligent mode
// - intelligent mode data reads return feh
// - intelligent mode data writes are dropped
// - 3fh: uart mode, ack byte, interrupt
// - ffh restores initial state, intelligent mode
// - received bytes queued, data reads pop them
// - interrupt while receive fill reaches trigger
// - trigger chosen by config bits 2-1
// - written bytes queued then sent in order
package mui_pkg;
  localparam logic MUI_OFS_DATA = 1'b0;
  localparam logic MUI_OFS_CMD = 1'b1;
  localparam logic [7:0] MUI_CMD_RESET = 8'hff;
  localparam logic [7:0] MUI_CMD_UART = 8'h3f;
  localparam logic [7:0] MUI_ACK_CODE = 8'hfe;
  localparam logic [5:0] MUI_STATUS_RSVD = 6'h3f;
  localparam int MUI_TRIG_LSB = 1;
  localparam int MUI_FIFO_DEPTH = 16;
  localparam int MUI_DATA_BITS = 8;
  localparam int MUI_CLK_PERIOD_NS = 100;
  // one bit at 31.25 Kbaud
  localparam int MUI_BIT_TIME_NS = 32000;
  localparam int MUI_BIT_CYCLES = MUI_BIT_TIME_NS / MUI_CLK_PERIOD_NS;
  localparam int MUI_TMR_W = $clog2(MUI_BIT_CYCLES);
  localparam logic [MUI_TMR_W-1:0] MUI_BIT_LAST = MUI_TMR_W'(MUI_BIT_CYCLES - 1);
  localparam logic [MUI_TMR_W-1:0] MUI_HALF_LAST = MUI_TMR_W'(MUI_BIT_CYCLES / 2 - 1);
  localparam logic [2:0] MUI_LAST_BIT = 3'h7;
  localparam logic [4:0] MUI_TRIG_L0 = 5'h01;
  localparam logic [4:0] MUI_TRIG_L1 = 5'h04;
  localparam logic [4:0] MUI_TRIG_L2 = 5'h08;
  localparam logic [4:0] MUI_TRIG_L3 = 5'h0e;

  typedef enum logic {MUI_INTEL = 1'b0, MUI_UART = 1'b1} mui_mode_t;
  typedef enum logic [1:0] {
    MUI_SER_IDLE = 2'b00,
    MUI_SER_START = 2'b01,
    MUI_SER_DATA = 2'b10,
    MUI_SER_STOP = 2'b11
  } mui_ser_t;

  function automatic logic [4:0] mui_trig(input logic [1:0] sel);
    case (sel)
      2'b00: mui_trig = MUI_TRIG_L0;
      2'b01: mui_trig = MUI_TRIG_L1;
      2'b10: mui_trig = MUI_TRIG_L2;
      default: mui_trig = MUI_TRIG_L3;
    endcase
  endfunction
endpackage

// File: tb/mui_midi_partner.sv
// instrument model: sends frames into the block and decodes the frames it sends
// assumes the block's 10 MHz clock and the bit timing of mui_pkg
`timescale 1ns/100ps
`default_nettype none
module mui_midi_partner
  import mui_pkg::*;
(
  input wire logic ref_clk,
  input wire logic serial_output_pin,
  output logic serial_input_pin,
  output logic got_valid,
  output logic [7:0] got_byte
);
  initial begin
    serial_input_pin = 1'b1; // line idles high
  end

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0}; // start low, lsb first, stop high
    for (int i = 0; i < 10; i++) begin
      serial_input_pin <= fr[i];
      repeat (MUI_BIT_CYCLES) @(posedge ref_clk); // fixed bit time
    end
  endtask

  // a start shorter than half a bit is taken as a glitch
  initial begin
    got_valid = 1'b0;
    got_byte = 8'h00;
    forever begin
      do @(posedge ref_clk); while (serial_output_pin !== 1'b0);
      repeat (MUI_BIT_CYCLES / 2) @(posedge ref_clk);
      if (serial_output_pin === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (MUI_BIT_CYCLES) @(posedge ref_clk);
          got_byte[i] = serial_output_pin; // lsb first
        end
        repeat (MUI_BIT_CYCLES) @(posedge ref_clk);
        if (serial_output_pin === 1'b1) begin // stop high
          got_valid = 1'b1;
          @(posedge ref_clk);
          got_valid = 1'b0;
        end
      end
    end
  end
endmodule // mui_midi_partner
`default_nettype wire

// File: tb/tb_midi_uart_interface.sv
// testbench for mui_core: host port reads and writes, serial frames both ways
// assumes mui_pkg and the partner model mui_midi_partner
`timescale 1ns/100ps
`default_nettype none
module tb_midi_uart_interface
  import mui_pkg::*;
;
  localparam logic [15:0] BASE = 16'h0300;
  localparam logic [15:0] ALT_BASE = 16'h0330;
  logic [15:0] cfg_base_addr = BASE;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] special_config_register = 8'h02;
  logic [3:0] cfg_irq_level = 4'h5;
  logic [7:0] io_rdata, got_byte, b;
  logic [3:0] irq_level;
  logic serial_input_pin, serial_output_pin, irq_req, got_valid;
  logic rx_buffer_empty_flag, tx_buffer_full_flag;
  logic rd_flag = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 51308;
  logic [7:0] exp_rd[$], exp_tx[$], rxq[$];
  logic [4:0] trig[4] = '{MUI_TRIG_L0, MUI_TRIG_L1, MUI_TRIG_L2, MUI_TRIG_L3};

  always #50 ref_clk = ~ref_clk;

  mui_core dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cfg_base_addr(cfg_base_addr),
    .cfg_irq_level(cfg_irq_level), .special_config_register(special_config_register),
    .serial_input_pin(serial_input_pin), .serial_output_pin(serial_output_pin),
    .irq_req(irq_req), .irq_level(irq_level), .rx_buffer_empty_flag(rx_buffer_empty_flag),
    .tx_buffer_full_flag(tx_buffer_full_flag)
  );

  mui_midi_partner p_u (
    .ref_clk(ref_clk), .serial_output_pin(serial_output_pin),
    .serial_input_pin(serial_input_pin), .got_valid(got_valid), .got_byte(got_byte)
  );

  task automatic final_report();
    $display("checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic bus(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
    io_rd <= r;
    io_wr <= w;
    io_addr <= a;
    io_wdata <= d;
    @(posedge ref_clk);
  endtask

  task automatic host_rd(input logic [15:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    bus(1'b1, 1'b0, a, 8'h00);
  endtask

  task automatic host_wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b0, 1'b1, a, d);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, BASE, 8'h00);
  endtask

  // result watcher: read data one cycle after a decoded read, bytes from the partner
  always @(posedge ref_clk)
    rd_flag <= io_rd && (io_addr == cfg_base_addr || io_addr == cfg_base_addr + 16'h1);
  always @(negedge ref_clk) begin
    if (rd_flag)
      check8(io_rdata, exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hxx);
    if (got_valid === 1'b1)
      check8(got_byte, exp_tx.size() > 0 ? exp_tx.pop_front() : 8'hxx);
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end

  initial begin
    int n;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    idle(2);
    chk1(irq_req, 1'b0);
    check8({4'h0, irq_level}, 8'h05);
    host_rd(BASE + 16'h1, 8'h3f);
    host_rd(BASE, MUI_ACK_CODE);
    host_wr(BASE, 8'h5a);
    host_wr(BASE + 16'h1, 8'h12);
    host_wr(BASE + 16'h2, MUI_CMD_UART);
    cfg_irq_level <= 4'h9;
    idle(2);
    chk1(irq_req, 1'b0);
    check8({4'h0, irq_level}, 8'h09);
    host_rd(BASE, MUI_ACK_CODE);
    host_wr(BASE + 16'h1, MUI_CMD_UART);
    idle(1);
    chk1(irq_req, 1'b1);
    host_rd(BASE + 16'h1, 8'h3f);
    host_rd(BASE, MUI_ACK_CODE);
    host_wr(BASE + 16'h1, 8'h12);
    host_wr(BASE + 16'h1, MUI_CMD_UART);
    idle(2);
    chk1(irq_req, 1'b0);
    host_rd(BASE + 16'h1, 8'hbf);
    idle(1);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      rxq.push_back(b);
      p_u.send_byte(b);
      chk1(rx_buffer_empty_flag, 1'b0);
      chk1(irq_req, i == 3);
    end
    for (int s = 0; s < 4; s++) begin
      special_config_register <= {5'h00, s[1:0], 1'b0};
      idle(2);
      chk1(irq_req, 5'h04 >= trig[s]);
    end
    special_config_register <= 8'h02;
    host_rd(BASE, rxq[0]);
    idle(2);
    chk1(irq_req, 1'b0);
    for (int i = 1; i < 4; i++) host_rd(BASE, rxq[i]);
    idle(2);
    chk1(rx_buffer_empty_flag, 1'b1);
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      exp_tx.push_back(b);
      host_wr(BASE, b);
    end
    idle(1);
    n = 0;
    while (exp_tx.size() != 0 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      final_report();
    end
    for (int i = 0; i < 17; i++) host_wr(BASE, 8'($random(seed)));
    idle(2);
    chk1(tx_buffer_full_flag, 1'b1);
    host_rd(BASE + 16'h1, 8'hff);
    host_wr(BASE + 16'h1, MUI_CMD_RESET);
    idle(2);
    chk1(tx_buffer_full_flag, 1'b0);
    host_rd(BASE + 16'h1, 8'h3f);
    host_rd(BASE, MUI_ACK_CODE);
    // move the window: the old command address must no longer decode
    cfg_base_addr <= ALT_BASE;
    host_wr(BASE + 16'h1, MUI_CMD_UART);
    idle(2);
    chk1(irq_req, 1'b0);
    host_wr(ALT_BASE + 16'h1, MUI_CMD_UART);
    idle(1);
    chk1(irq_req, 1'b1);
    // reset in mid-run drops uart mode and the pending acknowledge
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(2);
    chk1(irq_req, 1'b0);
    host_rd(ALT_BASE + 16'h1, 8'h3f);
    // a frame from this byte would reach the partner with nothing expected
    host_wr(ALT_BASE, 8'h77);
    idle(4000);
    final_report();
  end
endmodule // tb_midi_uart_interface
`default_nettype wire
